// ### core/ccs_params.svh
// constants for the clock switch and reference output block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define CCS_OFS_OSC_CTRL 6'h00
`define CCS_OFS_REFOUT_CTRL 6'h01

`define CCS_KEY_HI_1 8'h78
`define CCS_KEY_HI_2 8'h9a
`define CCS_KEY_LO_1 8'h46
`define CCS_KEY_LO_2 8'h57

`define CCS_BIT_REQ 0
`define CCS_BIT_SECONDARY_SOURCE 1
`define CCS_BIT_KEEP 2
`define CCS_BIT_CF 3
`define CCS_BIT_PLL_LOCK 5
`define CCS_BIT_SEL_LOCK 7
`define CCS_POS_NEW 8
`define CCS_POS_CUR 12

`define CCS_BIT_RO_EN 15
`define CCS_BIT_RO_SLP 13
`define CCS_BIT_RO_SEL 12
`define CCS_POS_RO_DIV 8

`define CCS_SRC_FRC 3'h0
`define CCS_SRC_FRC_PLL 3'h1
`define CCS_SRC_PRI 3'h2
`define CCS_SRC_PRI_PLL 3'h3
`define CCS_SRC_SEC 3'h4
`define CCS_SRC_LOW_POWER_RC_SOURCE 3'h5
`define CCS_SRC_FRC_DIV 3'h7

`define CCS_SUB_EC 2'h0

`define CCS_ON_FRC 0
`define CCS_ON_PRI 1
`define CCS_ON_SEC 2
`define CCS_ON_LOW_POWER_RC_SOURCE 3
`define CCS_ON_PLL 4

`define CCS_SETTLE_CYCLES 4'ha
`define CCS_UNL_IDLE 2'h0
`define CCS_UNL_HALF 2'h1
`define CCS_UNL_OPEN 2'h2

`endif

// ### core/ccs_pkg.sv
// types shared by the clock switch block
package ccs_pkg;
`include "ccs_params.svh"

   typedef logic [2:0] ccs_src_t;
   typedef logic [4:0] ccs_on_t;

   typedef enum logic [1:0] {
      CCS_IDLE,
      CCS_CHECK,
      CCS_WAIT,
      CCS_SETTLE
   } ccs_fsm_e;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      ccs_src_t cur;
      ccs_src_t nsel;
      logic req;
      logic sel_lock;
      logic pll_lock;
      logic cf;
      logic keep;
      logic secondary_source;
      logic [1:0] hi_st;
      logic [1:0] lo_st;
      ccs_fsm_e fsm;
      logic [3:0] cnt;
      ccs_on_t on;
      ccs_on_t src_en;
      logic ro_en;
      logic ro_slp;
      logic ro_sel;
      logic [3:0] ro_div;
      logic ro_oe;
   } ccs_state_s;
endpackage

// ### core/ccs_refout_div.sv
// power-of-two divider that drives the reference output pin
`timescale 1ns/1ps
module ccs_refout_div #(
   parameter int DIV_BITS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic base_tick,
   input wire logic [DIV_BITS-1:0] divisor,
   output logic pin
);
   localparam int CW = (1 << DIV_BITS) - 1;

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic pin_reg;
   logic pin_next;
   logic [CW-1:0] limit;

   // each base tick is one base clock edge; toggling every 2^n ticks divides by 2^n
   always_comb begin
      limit = CW'((32'h1 << divisor) - 32'h1);
      cnt_next = cnt_reg;
      pin_next = pin_reg;
      if (!run) begin
         cnt_next = '0;
         pin_next = 1'b0;
      end else if (base_tick) begin
         if (cnt_reg >= limit) begin
            cnt_next = '0;
            pin_next = ~pin_reg;
         end else begin
            cnt_next = cnt_reg + CW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         pin_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         pin_reg <= pin_next;
      end
   end

   assign pin = pin_reg;
endmodule

// ### core/ccs_clock_switch.sv
// clock source switching with unlock sequences and reference clock output
//////////////////////////////////////////////////////////////////////////////
// What this block does
// [R1] switching and fail-safe monitor work only when config bit is zero
// [R2] switching off: new-source field ignored, current follows default config
// [R3] switching off: switch request has no effect and reads zero
// [R4] high byte writable only right after 78h then 9Ah writes
// [R5] low byte writable only right after 46h then 57h writes
// [R6] request with current equal new clears request and aborts
// [R7] valid switch start clears PLL lock status and clock-fail flag
// [R8] enable new source; wait start-up timer for crystal, lock for PLL
// [R9] count ten new-clock cycles before moving the system clock
// [R10] on changeover clear request and copy new into current
// [R11] turn old source off, keep low-power RC and secondary as needed
// [R12] bus keeps answering normally throughout a switch
// [R13] software must pass through fast RC between the two PLL modes
// [R14] primary submode fixed by configuration, never by software
// [R15] software polls request bit, then lock bit on failure
// [R16] software keeps interrupts off during unlock and write
// [R17] reference enable bit drives divided reference onto the pin
// [R18] divisor code n divides base clock by two to the n
// [R19] source-select one picks primary oscillator, zero the system clock
// [R20] sleep-run bit keeps reference running during sleep
// [R21] sleep reference needs both bits and primary mode; else primary stops unless the keep bit is set
// [R22] source fields use the fixed three-bit encoding
// [R23] monitor on and selection lock set refuse selection changes
// [R24] any other access after an unlock pair closes the window
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_switch (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SWITCH_MONITOR_CFG,
   input wire ccs_pkg::ccs_src_t DEFAULT_SOURCE_CFG,
   input wire logic [1:0] PRIMARY_SUBMODE_CFG,
   input wire logic WATCHDOG_ON,
   input wire logic SLEEP,
   input wire logic FRC_TICK,
   input wire logic PRI_TICK,
   input wire logic SEC_TICK,
   input wire logic LOW_POWER_RC_SOURCE_TICK,
   input wire logic PLL_TICK,
   input wire logic OSC_STARTUP_DONE,
   input wire logic PLL_LOCKED,
   input wire logic CLOCK_FAIL,
   output ccs_pkg::ccs_on_t SRC_ENABLE,
   output ccs_pkg::ccs_src_t SYS_SOURCE,
   output logic REFOUT_PIN,
   output logic REFOUT_OE
);
   import ccs_pkg::*;

   ccs_state_s s_reg;
   ccs_state_s s_next;

   //////////////////////////////////////////////////////////////////////////
   // source helpers

   // oscillators and PLL that a source code needs
   function automatic ccs_on_t src_mask(input ccs_src_t src);
      ccs_on_t m;
      m = '0;
      // [R22] source code meaning
      case (src)
         `CCS_SRC_FRC, `CCS_SRC_FRC_DIV: m[`CCS_ON_FRC] = 1'b1;
         `CCS_SRC_FRC_PLL: begin
            m[`CCS_ON_FRC] = 1'b1;
            m[`CCS_ON_PLL] = 1'b1;
         end
         `CCS_SRC_PRI: m[`CCS_ON_PRI] = 1'b1;
         `CCS_SRC_PRI_PLL: begin
            m[`CCS_ON_PRI] = 1'b1;
            m[`CCS_ON_PLL] = 1'b1;
         end
         `CCS_SRC_SEC: m[`CCS_ON_SEC] = 1'b1;
         `CCS_SRC_LOW_POWER_RC_SOURCE: m[`CCS_ON_LOW_POWER_RC_SOURCE] = 1'b1;
         default: m = '0;
      endcase
      return m;
   endfunction

   // clock edge tick of the clock that a source code delivers
   function automatic logic src_tick(input ccs_src_t src, input logic [4:0] t);
      logic k;
      case (src)
         `CCS_SRC_FRC, `CCS_SRC_FRC_DIV: k = t[`CCS_ON_FRC];
         `CCS_SRC_FRC_PLL, `CCS_SRC_PRI_PLL: k = t[`CCS_ON_PLL];
         `CCS_SRC_PRI: k = t[`CCS_ON_PRI];
         `CCS_SRC_SEC: k = t[`CCS_ON_SEC];
         `CCS_SRC_LOW_POWER_RC_SOURCE: k = t[`CCS_ON_LOW_POWER_RC_SOURCE];
         default: k = 1'b0;
      endcase
      return k;
   endfunction

   function automatic logic is_primary(input ccs_src_t src);
      return (src == `CCS_SRC_PRI) || (src == `CCS_SRC_PRI_PLL);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // combinational view of the configuration

   logic switch_on;
   logic monitor_on;
   logic sel_locked;
   logic [4:0] ticks;
   logic acc;
   logic hit_osc;
   logic hit_ref;
   logic wr_hi;
   logic wr_lo;
   logic hi_ok;
   logic lo_ok;
   logic new_tick;
   logic crystal;
   logic ready;
   logic ref_sleep_ok;
   logic ro_run;
   logic base_tick;
   ccs_on_t keep_mask;
   ccs_on_t new_mask;

   always_comb begin
      // [R1] config bit programmed to zero enables switching and monitor
      switch_on = ~SWITCH_MONITOR_CFG;
      monitor_on = ~SWITCH_MONITOR_CFG;
      // [R23] lock only bites with the monitor enabled
      sel_locked = monitor_on & s_reg.sel_lock;
      ticks = {PLL_TICK, LOW_POWER_RC_SOURCE_TICK, SEC_TICK, PRI_TICK, FRC_TICK};
      acc = WB_CYC_I & WB_STB_I & ~s_reg.ack;
      hit_osc = WB_ADR_I[7:2] == `CCS_OFS_OSC_CTRL;
      hit_ref = WB_ADR_I[7:2] == `CCS_OFS_REFOUT_CTRL;
      wr_hi = acc & WB_WE_I & hit_osc & WB_SEL_I[1];
      wr_lo = acc & WB_WE_I & hit_osc & WB_SEL_I[0];
      // [R4] high byte open only for the write after the key pair
      hi_ok = wr_hi & (s_reg.hi_st == `CCS_UNL_OPEN);
      // [R5] low byte open only for the write after the key pair
      lo_ok = wr_lo & (s_reg.lo_st == `CCS_UNL_OPEN);
      new_tick = src_tick(s_reg.nsel, ticks);
      new_mask = src_mask(s_reg.nsel);
      // [R14] submode comes only from configuration; EC needs no start-up wait
      crystal = PRIMARY_SUBMODE_CFG != `CCS_SUB_EC;
      // [R8] crystal waits on start-up timer if it was off at check, PLL on lock
      ready = 1'b1;
      if (s_reg.cnt[0]) begin
         ready = ready & OSC_STARTUP_DONE;
      end
      if (new_mask[`CCS_ON_PLL]) begin
         ready = ready & PLL_LOCKED;
      end
      // [R11] sources that must outlive a changeover
      keep_mask = '0;
      keep_mask[`CCS_ON_LOW_POWER_RC_SOURCE] = WATCHDOG_ON | monitor_on;
      keep_mask[`CCS_ON_SEC] = s_reg.secondary_source;
      // [R21] sleep reference needs both bits and a primary mode
      ref_sleep_ok = s_reg.ro_slp & s_reg.ro_sel & is_primary(s_reg.cur);
      // [R17] [R20] pin runs when enabled, and in sleep only if allowed
      ro_run = s_reg.ro_en & (~SLEEP | ref_sleep_ok);
      // [R19] base clock is primary or the current system clock
      base_tick = s_reg.ro_sel ? PRI_TICK : src_tick(s_reg.cur, ticks);
   end

   //////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_next = s_reg;

      // [R12] single-cycle ack regardless of any switch in progress
      s_next.ack = acc;
      if (acc) begin
         s_next.dat = '0;
         if (!WB_WE_I && hit_osc) begin
            s_next.dat[`CCS_POS_CUR +: 3] = s_reg.cur;
            s_next.dat[`CCS_POS_NEW +: 3] = s_reg.nsel;
            s_next.dat[`CCS_BIT_SEL_LOCK] = s_reg.sel_lock;
            s_next.dat[`CCS_BIT_PLL_LOCK] = s_reg.pll_lock;
            s_next.dat[`CCS_BIT_CF] = s_reg.cf;
            s_next.dat[`CCS_BIT_KEEP] = s_reg.keep;
            s_next.dat[`CCS_BIT_SECONDARY_SOURCE] = s_reg.secondary_source;
            s_next.dat[`CCS_BIT_REQ] = s_reg.req;
         end else if (!WB_WE_I && hit_ref) begin
            s_next.dat[`CCS_BIT_RO_EN] = s_reg.ro_en;
            s_next.dat[`CCS_BIT_RO_SLP] = s_reg.ro_slp;
            s_next.dat[`CCS_BIT_RO_SEL] = s_reg.ro_sel;
            s_next.dat[`CCS_POS_RO_DIV +: 4] = s_reg.ro_div;
         end
      end

      // [R24] any access other than the next key closes it, the open write included
      if (acc) begin
         if (wr_hi && WB_DAT_I[15:8] == `CCS_KEY_HI_1) begin
            s_next.hi_st = `CCS_UNL_HALF;
         end else if (wr_hi && s_reg.hi_st == `CCS_UNL_HALF &&
                      WB_DAT_I[15:8] == `CCS_KEY_HI_2) begin
            s_next.hi_st = `CCS_UNL_OPEN;
         end else begin
            s_next.hi_st = `CCS_UNL_IDLE;
         end
         if (wr_lo && WB_DAT_I[7:0] == `CCS_KEY_LO_1) begin
            s_next.lo_st = `CCS_UNL_HALF;
         end else if (wr_lo && s_reg.lo_st == `CCS_UNL_HALF &&
                      WB_DAT_I[7:0] == `CCS_KEY_LO_2) begin
            s_next.lo_st = `CCS_UNL_OPEN;
         end else begin
            s_next.lo_st = `CCS_UNL_IDLE;
         end
      end

      // [R4] unlocked high byte sets the new selection
      if (hi_ok && switch_on && !sel_locked) begin
         s_next.nsel = WB_DAT_I[`CCS_POS_NEW +: 3];
      end

      // [R5] unlocked low byte: lock is set-only, fail flag clear-only
      if (lo_ok) begin
         s_next.sel_lock = s_reg.sel_lock | WB_DAT_I[`CCS_BIT_SEL_LOCK];
         s_next.keep = WB_DAT_I[`CCS_BIT_KEEP];
         s_next.secondary_source = WB_DAT_I[`CCS_BIT_SECONDARY_SOURCE];
         if (!WB_DAT_I[`CCS_BIT_CF]) begin
            s_next.cf = 1'b0;
         end
         // hardware owns the request once a switch is under way
         if (switch_on && !sel_locked && s_reg.fsm == CCS_IDLE) begin
            s_next.req = WB_DAT_I[`CCS_BIT_REQ];
         end
      end

      if (acc && WB_WE_I && hit_ref) begin
         if (WB_SEL_I[1]) begin
            s_next.ro_en = WB_DAT_I[`CCS_BIT_RO_EN];
            s_next.ro_slp = WB_DAT_I[`CCS_BIT_RO_SLP];
            s_next.ro_sel = WB_DAT_I[`CCS_BIT_RO_SEL];
            s_next.ro_div = WB_DAT_I[`CCS_POS_RO_DIV +: 4];
         end
      end

      s_next.pll_lock = s_reg.on[`CCS_ON_PLL] & PLL_LOCKED;
      if (s_reg.secondary_source) begin
         s_next.on[`CCS_ON_SEC] = 1'b1;
      end

      case (s_reg.fsm)
         CCS_IDLE: begin
            if (s_reg.req) begin
               s_next.fsm = CCS_CHECK;
            end
         end
         CCS_CHECK: begin
            if (s_reg.cur == s_reg.nsel) begin
               // [R6] redundant switch is aborted
               s_next.req = 1'b0;
               s_next.fsm = CCS_IDLE;
            end else begin
               // [R7] fresh status for the new attempt
               s_next.pll_lock = 1'b0;
               s_next.cf = 1'b0;
               // [R8] start the new source if not running
               s_next.on = s_reg.on | new_mask;
               // on is already set while waiting, so the start-up debt is kept in cnt
               s_next.cnt = {3'h0, is_primary(s_reg.nsel) & crystal & ~s_reg.on[`CCS_ON_PRI]};
               s_next.fsm = CCS_WAIT;
            end
         end
         CCS_WAIT: begin
            if (ready) begin
               s_next.cnt = '0;
               s_next.fsm = CCS_SETTLE;
            end
         end
         CCS_SETTLE: begin
            // [R9] ten new-clock cycles before the changeover
            if (new_tick) begin
               if (s_reg.cnt == `CCS_SETTLE_CYCLES - 4'h1) begin
                  // [R10] report success and adopt the new source
                  s_next.req = 1'b0;
                  s_next.cur = s_reg.nsel;
                  // [R11] old source off except those still needed
                  s_next.on = src_mask(s_reg.nsel) | keep_mask;
                  s_next.fsm = CCS_IDLE;
               end else begin
                  s_next.cnt = s_reg.cnt + 4'h1;
               end
            end
         end
         default: s_next.fsm = CCS_IDLE;
      endcase

      // monitor event wins over any clear in the same cycle
      if (CLOCK_FAIL && monitor_on) begin
         s_next.cf = 1'b1;
      end

      if (!switch_on) begin
         // [R2] current follows the default source configuration
         s_next.cur = DEFAULT_SOURCE_CFG;
         s_next.nsel = DEFAULT_SOURCE_CFG;
         // [R3] request held at zero
         s_next.req = 1'b0;
         s_next.fsm = CCS_IDLE;
         s_next.on = src_mask(DEFAULT_SOURCE_CFG) | keep_mask;
      end

      s_next.src_en = s_next.on;
      // [R21] primary powers down in sleep unless kept
      if (SLEEP && !s_next.keep && !ref_sleep_ok) begin
         s_next.src_en[`CCS_ON_PRI] = 1'b0;
      end
      // [R17] output enable follows enable bit
      s_next.ro_oe = s_next.ro_en;
   end

   //////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         s_reg <= '0;
         s_reg.fsm <= CCS_IDLE;
         // sync reset, so the configuration can be taken directly
         s_reg.cur <= DEFAULT_SOURCE_CFG;
         s_reg.nsel <= DEFAULT_SOURCE_CFG;
         s_reg.on <= src_mask(DEFAULT_SOURCE_CFG);
         s_reg.src_en <= src_mask(DEFAULT_SOURCE_CFG);
      end else begin
         s_reg <= s_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // reference divider

   // [R18] divide by two to the divisor code
   ccs_refout_div #(
      .DIV_BITS(4)
   ) u_div (
      .clk(MCLK),
      .rst_n(RST_B),
      .run(ro_run),
      .base_tick(base_tick),
      .divisor(s_reg.ro_div),
      .pin(REFOUT_PIN)
   );

   assign WB_DAT_O = s_reg.dat;
   assign WB_ACK_O = s_reg.ack;
   assign SRC_ENABLE = s_reg.src_en;
   assign SYS_SOURCE = s_reg.cur;
   assign REFOUT_OE = s_reg.ro_oe;
endmodule

// ### test/ccs_clock_switch_chk.sv
// port assertions for the clock switch block
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_switch_chk
   import ccs_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic SWITCH_MONITOR_CFG,
   input wire ccs_pkg::ccs_src_t DEFAULT_SOURCE_CFG,
   input wire logic SLEEP,
   input wire logic FRC_TICK,
   input wire logic PRI_TICK,
   input wire logic SEC_TICK,
   input wire logic LOW_POWER_RC_SOURCE_TICK,
   input wire logic PLL_TICK,
   input wire ccs_pkg::ccs_on_t SRC_ENABLE,
   input wire ccs_pkg::ccs_src_t SYS_SOURCE,
   input wire logic REFOUT_PIN,
   input wire logic REFOUT_OE
);
   function automatic logic [4:0] need(input logic [2:0] s);
      case (s)
         `CCS_SRC_FRC_PLL: need = 5'h11;
         `CCS_SRC_PRI: need = 5'h02;
         `CCS_SRC_PRI_PLL: need = 5'h12;
         `CCS_SRC_SEC: need = 5'h04;
         `CCS_SRC_LOW_POWER_RC_SOURCE: need = 5'h08;
         default: need = 5'h01;
      endcase
   endfunction
   wire logic [4:0] tk = {PLL_TICK, LOW_POWER_RC_SOURCE_TICK, SEC_TICK, PRI_TICK, FRC_TICK};
   wire logic [4:0] nd = need(SYS_SOURCE);
   // pll sources settle on the pll tick
   wire logic [4:0] tm = nd[4] ? 5'h10 : nd;
   wire logic pri = (SYS_SOURCE == `CCS_SRC_PRI) || (SYS_SOURCE == `CCS_SRC_PRI_PLL);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_asleep;
      (SLEEP && !pri)[*3];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_bus_answers:
      assert property (s_req |=> WB_ACK_O) else $error("request not answered");
   a_ack_pulse:
      assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   a_fixed_source:
      assert property (SWITCH_MONITOR_CFG |-> SYS_SOURCE == DEFAULT_SOURCE_CFG)
      else $error("source moved while switching disabled");
   a_switch_on_tick:
      assert property ($changed(SYS_SOURCE) |-> (($past(tk) | $past(tk, 2)) & tm) != 5'h00)
      else $error("source changed without a new-clock tick");
   a_new_src_on:
      assert property ($changed(SYS_SOURCE) |-> ($past(SRC_ENABLE) & nd) == nd)
      else $error("new source not running before change");
   a_old_src_off:
      assert property ($changed(SYS_SOURCE) |-> ##[0:2] (SRC_ENABLE & ~(nd | 5'h0c)) == 5'h00)
      else $error("old source left running");
   a_refout_quiet:
      assert property (!REFOUT_OE && $past(!REFOUT_OE) |-> !REFOUT_PIN)
      else $error("reference pin active while disabled");
   a_sleep_stops:
      assert property (s_asleep |-> !REFOUT_PIN) else $error("reference runs in sleep");
endmodule
bind ccs_clock_switch ccs_clock_switch_chk ccs_clock_switch_chk_inst (.MCLK(MCLK),
   .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
   .SWITCH_MONITOR_CFG(SWITCH_MONITOR_CFG), .DEFAULT_SOURCE_CFG(DEFAULT_SOURCE_CFG),
   .SLEEP(SLEEP), .FRC_TICK(FRC_TICK), .PRI_TICK(PRI_TICK), .SEC_TICK(SEC_TICK),
   .LOW_POWER_RC_SOURCE_TICK(LOW_POWER_RC_SOURCE_TICK), .PLL_TICK(PLL_TICK), .SRC_ENABLE(SRC_ENABLE),
   .SYS_SOURCE(SYS_SOURCE), .REFOUT_PIN(REFOUT_PIN), .REFOUT_OE(REFOUT_OE));

// ### test/test_ccs_clock_switch.sv
// self-checking bench for the clock switch block
`timescale 1ns/1ps
`include "ccs_params.svh"
module test_ccs_clock_switch;
   import ccs_pkg::*;
   logic MCLK = 1'b0, RST_B = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'h0;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
   logic WB_ACK_O, SWITCH_MONITOR_CFG = 1'b1, WATCHDOG_ON = 1'b0, SLEEP = 1'b0;
   logic OSC_STARTUP_DONE = 1'b1, PLL_LOCKED = 1'b1, CLOCK_FAIL = 1'b0, REFOUT_PIN, REFOUT_OE;
   logic [1:0] PRIMARY_SUBMODE_CFG = 2'h1;
   logic [4:0] tk = 5'h00;
   ccs_src_t DEFAULT_SOURCE_CFG = `CCS_SRC_PRI, SYS_SOURCE;
   ccs_on_t SRC_ENABLE;
   int fails = 0, checks_done = 0;
   // pll modes reached via fast RC
   int tg[8] = '{2, 4, 5, 7, 1, 0, 3, 0};
   logic [7:0] cs[9] = '{8'h40, 8'h51, 8'h42, 8'h53, 8'h44, 8'h03, 8'hc2, 8'hf3, 8'hd2};
   ccs_clock_switch ccs_clock_switch_inst (.MCLK(MCLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
      .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
      .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
      .SWITCH_MONITOR_CFG(SWITCH_MONITOR_CFG), .DEFAULT_SOURCE_CFG(DEFAULT_SOURCE_CFG),
      .PRIMARY_SUBMODE_CFG(PRIMARY_SUBMODE_CFG), .WATCHDOG_ON(WATCHDOG_ON), .SLEEP(SLEEP),
      .FRC_TICK(tk[0]), .PRI_TICK(tk[1]), .SEC_TICK(tk[2]), .LOW_POWER_RC_SOURCE_TICK(tk[3]),
      .PLL_TICK(tk[4]), .OSC_STARTUP_DONE(OSC_STARTUP_DONE), .PLL_LOCKED(PLL_LOCKED),
      .CLOCK_FAIL(CLOCK_FAIL), .SRC_ENABLE(SRC_ENABLE), .SYS_SOURCE(SYS_SOURCE),
      .REFOUT_PIN(REFOUT_PIN), .REFOUT_OE(REFOUT_OE));
   initial begin
      forever #4 MCLK = ~MCLK;
   end
   // random source clocks keep every settle count honest; seeded once in this thread
   initial begin
      void'($urandom(83417));
      forever begin
         @(posedge MCLK);
         tk <= 5'($urandom);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_cnt(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         fails++;
         $display("Error at %0t: ticks %0d expected %0d", $time, got, exp);
      end
   endtask
   // every access is one instruction: request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      n = 0;
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_SEL_I <= s;
      WB_DAT_I <= d;
      do begin
         @(posedge MCLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         $display("Error at %0t: bus timeout", $time);
         test_done();
      end
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge MCLK);
   endtask
   // keys and write back to back
   task automatic oscw(input logic hi, input logic [7:0] b);
      wb(1'b1, 8'h00, hi ? 4'h2 : 4'h1, hi ? 32'h7800 : 32'h0046);
      wb(1'b1, 8'h00, hi ? 4'h2 : 4'h1, hi ? 32'h9a00 : 32'h0057);
      wb(1'b1, 8'h00, hi ? 4'h2 : 4'h1, hi ? {16'h0, b, 8'h0} : {24'h0, b});
   endtask
   function automatic logic [31:0] osc(input int c, input int s, input int k, input int f,
                                       input int r);
      osc = 32'((c << 12) | (s << 8) | (k << 5) | (f << 3) | r);
   endfunction
   task automatic do_reset(input logic c, input ccs_src_t d);
      RST_B <= 1'b0;
      SWITCH_MONITOR_CFG <= c;
      DEFAULT_SOURCE_CFG <= d;
      repeat (16) @(posedge MCLK);
      RST_B <= 1'b1;
      @(posedge MCLK);
   endtask
   // ticks of base b between two pin toggles, -1 if the pin stands still
   task automatic meas(input int b, output int n);
      logic p;
      int t, c, seen;
      seen = 0;
      c = 0;
      n = -1;
      @(negedge MCLK);
      p = REFOUT_PIN;
      for (t = 0; t < 800; t++) begin
         @(negedge MCLK);
         if (REFOUT_PIN !== p) begin
            p = REFOUT_PIN;
            if (seen) break;
            seen = 1;
            c = 0;
         end
         c += int'(tk[b]);
      end
      n = seen && t < 800 ? c : -1;
      @(posedge MCLK);
   endtask
   initial begin
      #(8 * 40000);
      fails++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int cur, n;
      @(posedge MCLK);
      do_reset(1'b1, `CCS_SRC_PRI);
      wb(1'b0, 8'h00, 4'hf, 32'h0);
      cmp_reg(rd, osc(2, 2, 0, 0, 0));
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      cmp_reg(rd, 32'h0);
      oscw(1'b0, 8'h01);
      wb(1'b0, 8'h00, 4'hf, 32'h0);
      cmp_reg(rd, osc(2, 2, 0, 0, 0));
      do_reset(1'b0, `CCS_SRC_FRC);
      wb(1'b1, 8'h00, 4'h2, 32'h0200);
      wb(1'b1, 8'h00, 4'h2, 32'h7800);
      wb(1'b1, 8'h00, 4'h2, 32'h9a00);
      wb(1'b0, 8'h00, 4'hf, 32'h0);
      wb(1'b1, 8'h00, 4'h2, 32'h0200);
      wb(1'b0, 8'h00, 4'hf, 32'h0);
      cmp_reg(rd, osc(0, 0, 0, 0, 0));
      oscw(1'b1, 8'h00);
      oscw(1'b0, 8'h01);
      repeat (10) @(posedge MCLK);
      wb(1'b0, 8'h00, 4'hf, 32'h0);
      cmp_reg(rd, osc(0, 0, 0, 0, 0));
      cur = 0;
      foreach (tg[i]) begin
         CLOCK_FAIL <= 1'b1;
         @(posedge MCLK);
         CLOCK_FAIL <= 1'b0;
         @(posedge MCLK);
         wb(1'b0, 8'h00, 4'hf, 32'h0);
         cmp_reg(rd, osc(cur, cur, int'(cur == 1 || cur == 3), 1, 0));
         OSC_STARTUP_DONE <= 1'b0;
         PLL_LOCKED <= 1'b0;
         oscw(1'b1, 8'(tg[i]));
         oscw(1'b0, 8'h09);
         wb(1'b0, 8'h00, 4'hf, 32'h0);
         cmp_reg(rd, osc(cur, tg[i], 0, 0, 1));
         repeat (40) @(posedge MCLK);
         if (tg[i] inside {1, 2, 3}) cmp_reg(32'(SYS_SOURCE), 32'(cur));
         OSC_STARTUP_DONE <= 1'b1;
         PLL_LOCKED <= 1'b1;
         n = 0;
         while (SYS_SOURCE !== 3'(tg[i]) && n < 500) begin
            @(posedge MCLK);
            n++;
         end
         cur = tg[i];
         cmp_reg(32'(SYS_SOURCE), 32'(cur));
      end
      foreach (cs[i]) begin
         wb(1'b1, 8'h04, 4'h2, {16'h0, cs[i][6], 1'b0, cs[i][5:0], 8'h0});
         wb(1'b0, 8'h04, 4'hf, 32'h0);
         cmp_reg(rd, {16'h0, cs[i][6], 1'b0, cs[i][5:0], 8'h0});
         cmp_reg(32'(REFOUT_OE), 32'(cs[i][6]));
         SLEEP <= cs[i][7];
         meas(cs[i][4] ? 1 : 0, n);
         cmp_cnt(n, cs[i][6] && !cs[i][7] ? 1 << cs[i][3:0] : -1);
         SLEEP <= 1'b0;
      end
      test_done();
   end
endmodule
